// file: design/chain_device_end.sv
// Purpose: Chained-readout and broadcast-write slave of one module
// Assumes: Link is on clk; event words arrive on the store write port
// Notes: Store depth is 2**CH_PTR_W words plus end flag
`timescale 1ns/1ps
`default_nettype none
`include "chain_link_map.svh"

module chain_device_end #(
   parameter logic [7:0] OWN_BASE = `CH_OWN_BASE
) (
   input  wire logic        clk,
   input  wire logic        reset_n,
   chain_link_if.dev        link,
   input  wire logic        evWrValid,
   input  wire logic [31:0] evWrData,
   input  wire logic        evWrEnd,
   output var  logic        evWrReady,
   output var  logic        drained,
   output var  logic        tokenOut
);

   localparam int DEPTH = 1 << `CH_PTR_W;

   chain_link_pkg::dev_state_t s_reg;
   chain_link_pkg::dev_state_t s_next;
   logic [32:0]                multiEventStore [DEPTH];

   logic [7:0]  upper;
   logic [23:0] ofs;
   logic        isFirst;
   logic        isLast;
   logic        tokenHeld;
   logic        storeEmpty;
   logic        storeFull;
   logic        newReq;
   logic        chainedRd;
   logic        broadcastWrite;
   logic        ownAcc;
   logic        isWide;
   logic        wrTake;
   logic [32:0] headWord;
   logic [31:0] regRead;
   logic [`CH_PTR_W:0] wrPtrNext;

   always_comb begin
      upper      = link.addr[31:24];
      ofs        = link.addr[23:0];
      isFirst    = s_reg.head && !s_reg.tail; // RL2
      isLast     = s_reg.tail && !s_reg.head; // RL2
      tokenHeld  = isFirst || link.tokenIn;
      storeEmpty = s_reg.wrPtr == s_reg.rdPtr;
      storeFull  = (s_reg.wrPtr[`CH_PTR_W] != s_reg.rdPtr[`CH_PTR_W]) &&
                   (s_reg.wrPtr[`CH_PTR_W-1:0] == s_reg.rdPtr[`CH_PTR_W-1:0]);
      newReq     = link.strobe && !s_reg.answered;
      isWide     = link.am == `CH_AM_MBLT64;
      chainedRd  = (upper == s_reg.commonUpper) && !link.write && // RL1 RL15
                   (link.am == `CH_AM_BLT32 || isWide) && // RL3
                   (ofs < `CH_STORE_LIMIT); // RL4
      broadcastWrite = (upper == s_reg.commonUpper) && link.write && // RL1 RL15
                       (link.am == `CH_AM_SINGLE);
      ownAcc     = (upper == OWN_BASE) && (link.am == `CH_AM_SINGLE);
      wrTake     = evWrValid && s_reg.evWrReady;
      headWord   = multiEventStore[s_reg.rdPtr[`CH_PTR_W-1:0]];
      regRead    = 32'h0;
      case (ofs)
         `CH_OFS_COMMON:  regRead = {24'h0, s_reg.commonUpper};
         `CH_OFS_CHAIN:   regRead = {30'h0, s_reg.tail, s_reg.head};
         `CH_OFS_OPTIONS: regRead = {31'h0, s_reg.advanceEn};
         `CH_OFS_STATUS:  regRead = {28'h0, storeFull, s_reg.tokenOut, storeEmpty,
                                     s_reg.drained};
         default:         regRead = 32'h0;
      endcase
   end

   always_comb begin
      s_next       = s_reg;
      s_next.dtack = 1'h0;
      s_next.berr  = 1'h0;
      if (!link.strobe) begin
         s_next.answered = 1'h0;
         s_next.rdataEn  = 1'h0; // RL18
      end
      if (!link.cycle) begin
         s_next.addrAcked = 1'h0;
      end
      if (newReq && chainedRd) begin
         if (tokenHeld) begin
            if (isWide && isFirst && !s_reg.addrAcked) begin
               s_next.dtack     = 1'h1; // RL9
               s_next.addrAcked = 1'h1;
               s_next.answered  = 1'h1;
            end else if (!s_reg.drained && !storeEmpty) begin
               s_next.rdata    = headWord[31:0]; // RL6
               s_next.rdataEn  = 1'h1;
               s_next.dtack    = 1'h1;
               s_next.answered = 1'h1;
               if (s_reg.advanceEn) begin
                  s_next.rdPtr = s_reg.rdPtr + 1'h1; // RL10
               end
               if (headWord[32] || !s_reg.advanceEn) begin
                  s_next.drained = 1'h1; // RL6 RL11
               end
            end else if (!s_reg.drained) begin
               s_next.drained = 1'h1;
            end else if (isLast) begin
               s_next.berr     = 1'h1; // RL8
               s_next.answered = 1'h1;
            end
         end
      end else if (newReq && link.write && (broadcastWrite || ownAcc)) begin
         s_next.dtack    = 1'h1; // RL14 RL17
         s_next.answered = 1'h1;
         case (ofs)
            `CH_OFS_COMMON: s_next.commonUpper = link.wdata[7:0];
            `CH_OFS_CHAIN: begin
               s_next.head = link.wdata[0];
               s_next.tail = link.wdata[1];
            end
            `CH_OFS_OPTIONS: s_next.advanceEn = link.wdata[0];
            `CH_OFS_STATUS: begin
               if (link.wdata[0]) begin
                  s_next.drained = 1'h0;
               end
            end
            default: s_next.answered = 1'h1;
         endcase
      end else if (newReq && ownAcc) begin
         s_next.rdata    = regRead;
         s_next.rdataEn  = 1'h1;
         s_next.dtack    = 1'h1;
         s_next.answered = 1'h1;
      end
      // Drained state survives between readouts so the next one resumes
      s_next.tokenOut = s_next.drained && tokenHeld; // RL7 RL13
      wrPtrNext       = s_reg.wrPtr + {{`CH_PTR_W{1'h0}}, wrTake};
      s_next.wrPtr    = wrPtrNext;
      s_next.evWrReady = !((wrPtrNext[`CH_PTR_W] != s_next.rdPtr[`CH_PTR_W]) &&
                           (wrPtrNext[`CH_PTR_W-1:0] == s_next.rdPtr[`CH_PTR_W-1:0]));
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_reg           <= '0;
         s_reg.advanceEn <= `CH_ADV_RESET;
         s_reg.evWrReady <= 1'h1;
      end else begin
         s_reg <= s_next;
      end
   end

   always_ff @(posedge clk) begin
      if (wrTake) begin
         multiEventStore[s_reg.wrPtr[`CH_PTR_W-1:0]] <= {evWrEnd, evWrData};
      end
   end

   assign link.rdata    = s_reg.rdata;
   assign link.rdataEn  = s_reg.rdataEn;
   assign link.dtack    = s_reg.dtack;
   assign link.berr     = s_reg.berr;
   assign link.tokenOut = s_reg.tokenOut;
   assign evWrReady     = s_reg.evWrReady;
   assign drained       = s_reg.drained;
   assign tokenOut      = s_reg.tokenOut;

endmodule // chain_device_end

`default_nettype wire

// file: design/chain_link_map.svh
// Purpose: Constants for the chained readout and broadcast link
// Assumes: One clock; link signals are synchronous logic
// Notes: Included by the package and both ends
// Behaviour
// (RL1) Shared base is upper byte, lower zero
// (RL2) Head only first, tail only last
// (RL3) Chained reads need block modifiers only
// (RL4) Chained reads reach only the event store
// (RL5) Master issues enough 34-word chained accesses
// (RL6) Head sends first, drains after end word
// (RL7) Drained module passes the token on
// (RL8) Drained tail holding token raises bus error
// (RL9) 64-bit chained read acknowledges address first
// (RL10) Advance on: pointer moves through each event
// (RL11) Advance off: pointer holds, header only
// (RL12) Master splits at 256; module tolerates more
// (RL13) Interrupted readout resumes at token holder
// (RL14) Broadcast write updates every module at once
// (RL15) Chained only reads, broadcast only writes
// (RL16) Never broadcast the common address register
// (RL17) Per-channel broadcast writes discouraged, still accepted
// (RL18) Non-participants keep data and acknowledge released
`ifndef CHAIN_LINK_MAP_SVH
`define CHAIN_LINK_MAP_SVH

`define CH_AM_BLT32      6'h0b
`define CH_AM_MBLT64     6'h08
`define CH_AM_SINGLE     6'h09
`define CH_STORE_LIMIT   24'h001000
`define CH_OFS_COMMON    24'h001000
`define CH_OFS_CHAIN     24'h001004
`define CH_OFS_OPTIONS   24'h001008
`define CH_OFS_STATUS    24'h00100c
`define CH_OWN_BASE      8'h20
`define CH_PTR_W         6
`define CH_MAX_BEATS     9'h100
`define CH_ADV_RESET     1'h1

`define HO_ADDR          8'h00
`define HO_MODE          8'h04
`define HO_WDATA         8'h08
`define HO_CTRL          8'h0c
`define HO_STATUS        8'h10
`define HO_RDATA         8'h14

`endif

// file: design/chain_link_pkg.sv
// Purpose: Types shared by both ends of the chained link
// Assumes: Constants come from the map header
// Notes: Each end's state, except the device event store, is one packed struct
`include "chain_link_map.svh"

package chain_link_pkg;

   typedef struct packed {
      logic [7:0]           commonUpper;
      logic                 head;
      logic                 tail;
      logic                 advanceEn;
      logic                 drained;
      logic                 answered;
      logic                 addrAcked;
      logic                 dtack;
      logic                 berr;
      logic                 rdataEn;
      logic                 tokenOut;
      logic [31:0]          rdata;
      logic [`CH_PTR_W:0]   wrPtr;
      logic [`CH_PTR_W:0]   rdPtr;
      logic                 evWrReady;
   } dev_state_t;

   typedef enum logic [1:0] {
      H_IDLE,
      H_WAIT
   } host_phase_t;

   typedef struct packed {
      host_phase_t          phase;
      logic [31:0]          linkAddr;
      logic [5:0]           linkAm;
      logic                 linkWrite;
      logic [31:0]          linkWdata;
      logic                 cycle;
      logic                 strobe;
      logic                 tokenIn;
      logic                 limitEn;
      logic [31:0]          lastRdata;
      logic                 lastDtack;
      logic                 lastBerr;
      logic                 limitHit;
      logic                 refused;
      logic [8:0]           beats;
      logic                 dpValid;
      logic                 dpWrite;
      logic [7:0]           dpAddr;
      logic [31:0]          hrdata;
      logic                 hreadyout;
   } host_state_t;

endpackage

// file: design/chain_link_if.sv
// Purpose: Backplane link between a bus master and one chained module
// Assumes: All signals change after the rising edge of the common clock
// Notes: No clocking block; the bench joins the two ends
`timescale 1ns/1ps
`default_nettype none

interface chain_link_if;
   logic [31:0] addr;
   logic [5:0]  am;
   logic        write;
   logic [31:0] wdata;
   logic        strobe;
   logic        cycle;
   logic        tokenIn;
   logic [31:0] rdata;
   logic        rdataEn;
   logic        dtack;
   logic        berr;
   logic        tokenOut;

   modport dev (
      input  addr, am, write, wdata, strobe, cycle, tokenIn,
      output rdata, rdataEn, dtack, berr, tokenOut
   );

   modport host (
      output addr, am, write, wdata, strobe, cycle, tokenIn,
      input  rdata, rdataEn, dtack, berr, tokenOut
   );
endinterface

`default_nettype wire

// file: design/chain_host_end.sv
// Purpose: Bus-master end driving the link from AHB-Lite registers
// Assumes: Zero-wait AHB-Lite slave, single word transfers only
// Notes: One link transfer per write of the start register
`timescale 1ns/1ps
`default_nettype none
`include "chain_link_map.svh"

module chain_host_end #(
   parameter logic [7:0] DEVICE_BASE = `CH_OWN_BASE,
   parameter logic [8:0] MAX_BEATS   = `CH_MAX_BEATS
) (
   input  wire logic        clk,
   input  wire logic        reset_n,
   chain_link_if.host       link,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output var  logic        hreadyout,
   output var  logic [31:0] hrdata,
   output var  logic        hresp
);

   chain_link_pkg::host_state_t s_reg;
   chain_link_pkg::host_state_t s_next;
   logic [31:0]                 rdMux;
   logic                        badTarget;

   always_comb begin
      // Writing the common address register by broadcast would corrupt it
      badTarget = s_reg.linkWrite && (s_reg.linkAddr[23:0] == `CH_OFS_COMMON) &&
                  (s_reg.linkAddr[31:24] != DEVICE_BASE); // RL16
      case (haddr[7:0])
         `HO_ADDR:   rdMux = s_reg.linkAddr;
         `HO_MODE:   rdMux = {23'h0, s_reg.linkWrite, 2'h0, s_reg.linkAm};
         `HO_WDATA:  rdMux = s_reg.linkWdata;
         `HO_CTRL:   rdMux = {29'h0, s_reg.tokenIn, s_reg.limitEn, s_reg.cycle};
         `HO_STATUS: rdMux = {7'h0, s_reg.beats, 10'h0, s_reg.refused, s_reg.limitHit,
                              link.tokenOut, s_reg.lastBerr, s_reg.lastDtack,
                              s_reg.phase == chain_link_pkg::H_WAIT};
         `HO_RDATA:  rdMux = s_reg.lastRdata;
         default:    rdMux = 32'h0;
      endcase
   end

   always_comb begin
      s_next           = s_reg;
      s_next.hreadyout = 1'h1;
      s_next.dpValid   = hsel && htrans[1] && hready && (hsize == 3'h2);
      s_next.dpWrite   = hwrite;
      s_next.dpAddr    = haddr[7:0];
      if (hsel && htrans[1] && hready) begin
         s_next.hrdata = rdMux;
      end
      if (s_reg.dpValid && s_reg.dpWrite) begin
         case (s_reg.dpAddr)
            `HO_ADDR:  s_next.linkAddr = hwdata;
            `HO_MODE: begin
               s_next.linkAm    = hwdata[5:0];
               s_next.linkWrite = hwdata[8];
            end
            `HO_WDATA: s_next.linkWdata = hwdata;
            `HO_CTRL: begin
               s_next.cycle   = hwdata[0];
               s_next.limitEn = hwdata[1];
               s_next.tokenIn = hwdata[2];
               if (!hwdata[0]) begin
                  s_next.beats    = 9'h0;
                  s_next.limitHit = 1'h0;
               end
            end
            `HO_STATUS: begin
               if (hwdata[0] && s_reg.phase == chain_link_pkg::H_IDLE) begin
                  s_next.refused = 1'h0;
                  if (badTarget) begin
                     s_next.refused = 1'h1; // RL16
                  end else if (s_reg.limitEn && s_reg.beats == MAX_BEATS) begin
                     s_next.limitHit = 1'h1; // RL12
                  end else begin
                     s_next.strobe = 1'h1;
                     s_next.phase  = chain_link_pkg::H_WAIT;
                  end
               end
            end
            default: s_next.refused = s_reg.refused;
         endcase
      end
      case (s_reg.phase)
         chain_link_pkg::H_IDLE: s_next.lastBerr = s_reg.lastBerr;
         chain_link_pkg::H_WAIT: begin
            if (link.dtack || link.berr) begin
               s_next.strobe    = 1'h0;
               s_next.phase     = chain_link_pkg::H_IDLE;
               s_next.lastDtack = link.dtack;
               s_next.lastBerr  = link.berr; // RL8
               if (link.rdataEn) begin
                  s_next.lastRdata = link.rdata;
               end
               // Beats counted per cycle so software sizes 34-word accesses
               if (s_reg.beats != 9'h1ff) begin
                  s_next.beats = s_reg.beats + 9'h1; // RL5 RL12
               end
            end
         end
         default: s_next.phase = chain_link_pkg::H_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_reg           <= '0;
         s_reg.hreadyout <= 1'h1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign link.addr    = s_reg.linkAddr;
   assign link.am      = s_reg.linkAm;
   assign link.write   = s_reg.linkWrite;
   assign link.wdata   = s_reg.linkWdata;
   assign link.strobe  = s_reg.strobe;
   assign link.cycle   = s_reg.cycle;
   assign link.tokenIn = s_reg.tokenIn;
   assign hreadyout    = s_reg.hreadyout;
   assign hrdata       = s_reg.hrdata;
   assign hresp        = 1'h0;

endmodule // chain_host_end

`default_nettype wire

// file: test/chain_link_asserts.sv
// Purpose: Link checks between host end and device end
// Assumes: Single clock, link signals sampled at rising edge
// Notes: Sees only link signals, not device state
`timescale 1ns/1ps
`default_nettype none

module chain_link_asserts #(
   parameter logic [7:0] OWN_BASE = 8'h20
) (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic [31:0] addr,
   input  wire logic [5:0]  am,
   input  wire logic        write,
   input  wire logic        strobe,
   input  wire logic        tokenIn,
   input  wire logic [31:0] rdata,
   input  wire logic        rdataEn,
   input  wire logic        dtack,
   input  wire logic        berr,
   input  wire logic        tokenOut
);
   logic blk;
   assign blk = (am == 6'h0b) || (am == 6'h08);

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   property p_blk_am;
      dtack && !write && addr[31:24] != OWN_BASE |-> blk;
   endproperty
   a_blk_am: assert property (p_blk_am)
      else $error("shared read answered with wrong modifier");
   property p_store;
      dtack && !write && blk |-> addr[23:12] == 12'h0;
   endproperty
   a_store: assert property (p_store)
      else $error("chained read answered outside event store");
   property p_berr_rd;
      berr |-> !write && blk;
   endproperty
   a_berr_rd: assert property (p_berr_rd)
      else $error("bus error outside chained read");
   property p_berr_tail;
      berr |-> tokenIn && tokenOut;
   endproperty
   a_berr_tail: assert property (p_berr_tail)
      else $error("bus error without drained token holder");
   property p_quiet;
      tokenOut && $past(tokenOut) && blk && !write |-> !dtack;
   endproperty
   a_quiet: assert property (p_quiet)
      else $error("drained module still acknowledges");
   property p_ack;
      dtack |-> strobe ##1 !dtack;
   endproperty
   a_ack: assert property (p_ack)
      else $error("acknowledge without request or too long");
   property p_berr_pulse;
      berr |-> strobe ##1 !berr;
   endproperty
   a_berr_pulse: assert property (p_berr_pulse)
      else $error("bus error without request or too long");
   property p_rel;
      $fell(strobe) |=> !rdataEn;
   endproperty
   a_rel: assert property (p_rel)
      else $error("data lines not released after request");
   property p_hold;
      rdataEn && $past(rdataEn) |-> $stable(rdata);
   endproperty
   a_hold: assert property (p_hold)
      else $error("read data moved while driven");
endmodule // chain_link_asserts

`default_nettype wire

// file: test/test_chained_block_readout_multicast.sv
// Purpose: Chained readout and broadcast writes driven over AHB-Lite
// Assumes: One device end faces the host end on one link
// Notes: Device is last in chain, then head for the 64-bit readout; token fed from host control
`timescale 1ns/1ps
`default_nettype none

module test_chained_block_readout_multicast;
   localparam logic [31:0] OWNA = 32'h20000000;
   localparam logic [31:0] CMNA = 32'h30000000;
   logic        clk;
   logic        reset_n;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hreadyout;
   logic [31:0] hrdata;
   logic        hresp;
   logic        evWrValid;
   logic [31:0] evWrData;
   logic        evWrEnd;
   logic        evWrReady;
   logic        drained;
   logic        tokenOut;
   logic [31:0] rd;
   logic [31:0] evt [6];
   int          mismatches;
   int          n_checks;

   chain_link_if lnk();
   chain_device_end #(.OWN_BASE(8'h20)) chain_device_end_inst (.clk(clk), .reset_n(reset_n),
      .link(lnk), .evWrValid(evWrValid), .evWrData(evWrData), .evWrEnd(evWrEnd),
      .evWrReady(evWrReady), .drained(drained), .tokenOut(tokenOut));
   chain_host_end #(.DEVICE_BASE(8'h20)) chain_host_end_inst (.clk(clk), .reset_n(reset_n),
      .link(lnk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));
   chain_link_asserts #(.OWN_BASE(8'h20)) chain_link_asserts_inst (.clk(clk),
      .reset_n(reset_n), .addr(lnk.addr), .am(lnk.am), .write(lnk.write), .strobe(lnk.strobe),
      .tokenIn(lnk.tokenIn), .rdata(lnk.rdata), .rdataEn(lnk.rdataEn), .dtack(lnk.dtack),
      .berr(lnk.berr), .tokenOut(lnk.tokenOut));

   task automatic results();
      if (mismatches == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic waitReady();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1) begin
         mismatches++;
         results();
      end
   endtask

   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      waitReady();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      waitReady();
      rd = hrdata;
   endtask

   // One link transfer, then poll busy; status left in rd
   task automatic xfer(input logic [31:0] a, input logic [5:0] am, input logic wr,
                       input logic [31:0] d);
      int n;
      ahb(1'b1, 8'h00, a);
      ahb(1'b1, 8'h04, {23'h0, wr, 2'h0, am});
      ahb(1'b1, 8'h08, d);
      ahb(1'b1, 8'h10, 32'h1);
      n = 0;
      do begin
         ahb(1'b0, 8'h10, 32'h0);
         n++;
      end while (rd[0] !== 1'b0 && n < 40);
      if (rd[0] !== 1'b0) begin
         mismatches++;
         results();
      end
   endtask

   task automatic wrDev(input logic [31:0] a, input logic [31:0] d);
      xfer(a, 6'h09, 1'b1, d);
      check({30'h0, rd[2:1]}, 32'h1);
   endtask

   // k: 1 expects acknowledge with data d, 2 expects bus error
   task automatic rdChk(input logic [31:0] a, input logic [5:0] am, input logic [31:0] d,
                        input logic [1:0] k);
      xfer(a, am, 1'b0, 32'h0);
      check({30'h0, rd[2:1]}, {30'h0, k});
      if (k == 2'h1) begin
         ahb(1'b0, 8'h14, 32'h0);
         check(rd, d);
      end
   endtask

   task automatic ev(input logic [31:0] d, input logic e);
      int n;
      evWrValid <= 1'b1;
      evWrData <= d;
      evWrEnd <= e;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (evWrReady !== 1'b1 && n < 20);
      if (evWrReady !== 1'b1) begin
         mismatches++;
         results();
      end
   endtask

   task automatic load(input int last);
      for (int i = 0; i <= last; i++)
         ev(evt[i], (i == 3) || (i == 5));
      evWrValid <= 1'b0;
   endtask

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   initial begin
      evt = '{32'ha0000002, 32'h00000011, 32'h00000022, 32'hc0000003, 32'ha0000000,
              32'hc0000004};
      mismatches = 0;
      n_checks = 0;
      reset_n = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      evWrValid = 1'b0;
      evWrData = 32'h0;
      evWrEnd = 1'b0;
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      check({29'h0, tokenOut, drained, evWrReady}, 32'h1);
      ahb(1'b0, 8'h10, 32'h0);
      check(rd, 32'h0);
      check({31'h0, hresp}, 32'h0);
      wrDev(OWNA + 32'h1000, 32'h30);
      wrDev(OWNA + 32'h1004, 32'h2);
      rdChk(OWNA + 32'h1004, 6'h09, 32'h2, 2'h1);
      // Broadcast write of the common address register is held back
      xfer(CMNA + 32'h1000, 6'h09, 1'b1, 32'h55);
      check({30'h0, rd[5], rd[0]}, 32'h2);
      rdChk(OWNA + 32'h1000, 6'h09, 32'h30, 2'h1);
      load(5);
      ahb(1'b1, 8'h0c, 32'h5);
      rdChk(CMNA, 6'h0b, evt[0], 2'h1);
      rdChk(CMNA, 6'h0b, evt[1], 2'h1);
      // Split readout: drop the cycle and start again
      ahb(1'b1, 8'h0c, 32'h4);
      ahb(1'b1, 8'h0c, 32'h5);
      rdChk(CMNA, 6'h0b, evt[2], 2'h1);
      rdChk(CMNA, 6'h0b, evt[3], 2'h1);
      check({30'h0, tokenOut, drained}, 32'h3);
      rdChk(CMNA, 6'h0b, 32'h0, 2'h2);
      wrDev(CMNA + 32'h100c, 32'h1);
      check({31'h0, drained}, 32'h0);
      rdChk(CMNA, 6'h0b, evt[4], 2'h1);
      rdChk(CMNA, 6'h0b, evt[5], 2'h1);
      rdChk(CMNA, 6'h0b, 32'h0, 2'h2);
      // Advance off: only the header comes out
      wrDev(OWNA + 32'h1008, 32'h0);
      wrDev(CMNA + 32'h100c, 32'h1);
      load(3);
      rdChk(CMNA, 6'h0b, evt[0], 2'h1);
      rdChk(CMNA, 6'h0b, 32'h0, 2'h2);
      // 64-bit readout as head of chain, same event again
      wrDev(CMNA + 32'h1008, 32'h1);
      wrDev(CMNA + 32'h100c, 32'h1);
      wrDev(OWNA + 32'h1004, 32'h1);
      ahb(1'b1, 8'h0c, 32'h0);
      ahb(1'b1, 8'h0c, 32'h1);
      xfer(CMNA, 6'h08, 1'b0, 32'h0);
      check({30'h0, rd[2:1]}, 32'h1);
      for (int i = 0; i < 4; i++)
         rdChk(CMNA, 6'h08, evt[i], 2'h1);
      check({31'h0, drained}, 32'h1);
      ahb(1'b0, 8'h10, 32'h0);
      check({23'h0, rd[24:16]}, 32'h5);
      rdChk(OWNA + 32'h100c, 6'h09, 32'h7, 2'h1);
      // Beat limit: 256 answered beats in one cycle, then the next start is held back
      ahb(1'b1, 8'h0c, 32'h0);
      ahb(1'b1, 8'h0c, 32'h3);
      for (int i = 0; i < 256; i++)
         xfer(OWNA + 32'h1008, 6'h09, 1'b0, 32'h0);
      check({23'h0, rd[24:16]}, 32'h100);
      xfer(OWNA + 32'h1008, 6'h09, 1'b0, 32'h0);
      check({30'h0, rd[4], rd[0]}, 32'h2);
      results();
   end
endmodule // test_chained_block_readout_multicast

`default_nettype wire
